// [core/pgs_generator.sv]
/*
 * One PWM generator channel with its status register: time base, buffered
 * period/duty reload, time-base snapshot, trigger handling, interrupt and
 * an AXI4-Lite register slave.
 * Assumes one 200 MHz clock; capture and trigger pins are asynchronous.
 */
// Chosen here: the AXI4-Lite register port and the placing of the registers.
//
// Notes on behaviour
// - Snapshot flag sets once the time base is latched into the snapshot register.
// - Writing one to the snapshot flag asks for a software capture.
// - While the snapshot flag is set, no further capture happens.
// - Pending reload reads one and blocks writes to period and duty.
// - Writing one to the reload request raises pending; request reads zero.
// - Push-pull phase is one in the second cycle, zero in the first.
// - Centre mode reports one during the second half of the cycle.
// - Cycle active reads one while a triggered cycle runs.
`timescale 1ns/1ps
`default_nettype none

module pgs_generator
    import pgs_pkg::*;
#(
    parameter int TB_W = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Asynchronous pins
    input wire logic capture_pin,
    input wire logic trigger_pin,
    // Outputs
    output logic pwm_a,
    output logic pwm_b,
    output logic irq
);

    // Elaboration check: time base no wider than the 16-bit data fields
    if (TB_W < 2 || TB_W > 16) begin : g_tb_w_check
        $error("TB_W must lie between 2 and 16");
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] sync1_q, sync2_q, sync3_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
            sync3_q <= 2'h0;
        end else begin
            sync1_q <= {trigger_pin, capture_pin};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    wire cap_pin_rise = sync2_q[0] & ~sync3_q[0];
    wire cycle_active_rise = sync2_q[1] & ~sync3_q[1];

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    logic aw_have_q, w_have_q, bvalid_q, awready_q, wready_q, arready_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic pending_q, snap_flag_q, cap_req_q, active_q, down_q, phase_q;

    wire aw_take = s_axi_awvalid & awready_q;
    wire w_take = s_axi_wvalid & wready_q;
    wire wr_fire = aw_have_q & w_have_q & ~bvalid_q;
    wire b_done = bvalid_q & s_axi_bready;
    wire ar_take = s_axi_arvalid & arready_q;
    wire r_done = rvalid_q & s_axi_rready;
    wire aw_have_d = (aw_have_q | aw_take) & ~wr_fire;
    wire w_have_d = (w_have_q | w_take) & ~wr_fire;
    wire bvalid_d = (bvalid_q | wr_fire) & ~b_done;
    wire rvalid_d = (rvalid_q | ar_take) & ~r_done;

    // Write decode, only low byte lanes carry register bits
    wire wr_status = wr_fire & (awaddr_q == OFS_STATUS) & wstrb_q[0];
    wire wr_ctrl = wr_fire & (awaddr_q == OFS_CTRL);
    wire wr_period = wr_fire & (awaddr_q == OFS_PERIOD);
    wire wr_duty = wr_fire & (awaddr_q == OFS_DUTY);
    wire wr_isr = wr_fire & (awaddr_q == OFS_IRQ_STATUS) & wstrb_q[0];
    wire wr_mask = wr_fire & (awaddr_q == OFS_IRQ_MASK);
    wire wr_mapped = wr_status | wr_ctrl | wr_period | wr_duty | wr_isr | wr_mask
        | (wr_fire & (awaddr_q == OFS_SNAPSHOT));
    wire data_blocked = pending_q & (wr_period | wr_duty);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awready_q <= ~aw_have_d & ~bvalid_d;
            wready_q <= ~w_have_d & ~bvalid_d;
            bvalid_q <= bvalid_d;
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                bresp_q <= (wr_mapped & ~data_blocked) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control, data and interrupt registers
    // ----------------------------------------------------------------
    pgs_ctrl_t ctrl_q;
    logic [TB_W-1:0] period_buf_q, duty_buf_q, period_act_q, duty_act_q;
    logic [TB_W-1:0] tb_q, snapshot_q;
    logic [IRQ_BITS-1:0] isr_q, mask_q;
    logic pwm_a_q, pwm_b_q, irq_q;

    function automatic logic [TB_W-1:0] merge(input logic [TB_W-1:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [15:0] res;
        res = 16'(old);
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res[TB_W-1:0];
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RESET;
            period_buf_q <= PERIOD_RESET[TB_W-1:0];
            duty_buf_q <= DUTY_RESET[TB_W-1:0];
            mask_q <= '0;
        end else begin
            if (wr_ctrl & wstrb_q[0]) begin
                ctrl_q <= wdata_q[3:0];
            end
            if (wr_mask & wstrb_q[0]) begin
                mask_q <= wdata_q[IRQ_BITS-1:0];
            end
            if (wr_period & ~pending_q) begin
                period_buf_q <= merge(period_buf_q, wdata_q, wstrb_q);
            end
            if (wr_duty & ~pending_q) begin
                duty_buf_q <= merge(duty_buf_q, wdata_q, wstrb_q);
            end
        end
    end

    // ----------------------------------------------------------------
    // Time base
    // ----------------------------------------------------------------
    wire [TB_W:0] tb_next = {1'b0, tb_q} + 1'b1;
    wire start = ctrl_q.enable & ~active_q & (~ctrl_q.ext_cycle_active | cycle_active_rise);
    wire cycle_end = active_q & (ctrl_q.centre ? (down_q & (tb_q <= 1))
                                               : (tb_next >= {1'b0, period_act_q}));
    // Idle generator reloads at once; running one waits for the cycle end
    wire reload_point = cycle_end | ~active_q;
    wire cap_event = ~snap_flag_q & (cap_req_q | cap_pin_rise);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tb_q <= '0;
            active_q <= 1'b0;
            down_q <= 1'b0;
            phase_q <= 1'b0;
        end else if (!ctrl_q.enable) begin
            tb_q <= '0;
            active_q <= 1'b0;
            down_q <= 1'b0;
            phase_q <= 1'b0;
        end else if (cycle_end) begin
            active_q <= ~ctrl_q.ext_cycle_active;
            tb_q <= '0;
            down_q <= 1'b0;
            phase_q <= ctrl_q.pushpull & ~phase_q;
        end else if (active_q) begin
            if (ctrl_q.centre & (down_q | tb_q >= period_act_q)) begin
                down_q <= 1'b1;
                tb_q <= tb_q - 1'b1;
            end else begin
                tb_q <= tb_next[TB_W-1:0];
            end
        end else if (start) begin
            active_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Reload, snapshot and interrupt state
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_act_q <= PERIOD_RESET[TB_W-1:0];
            duty_act_q <= DUTY_RESET[TB_W-1:0];
            pending_q <= 1'b0;
            snap_flag_q <= 1'b0;
            cap_req_q <= 1'b0;
            snapshot_q <= '0;
            isr_q <= '0;
        end else begin
            if (wr_status & wdata_q[BIT_RELOAD_REQ]) begin
                pending_q <= 1'b1;
            end else if (pending_q & reload_point) begin
                period_act_q <= period_buf_q;
                duty_act_q <= duty_buf_q;
                pending_q <= 1'b0;
            end
            if (cap_event) begin
                snapshot_q <= tb_q;
                snap_flag_q <= 1'b1;
                cap_req_q <= 1'b0;
            end else if (wr_status & ~wdata_q[BIT_SNAPSHOT]) begin
                snap_flag_q <= 1'b0;
            end else if (wr_status & wdata_q[BIT_SNAPSHOT] & ~snap_flag_q) begin
                cap_req_q <= 1'b1;
            end
            // Event set wins over write-one-to-clear
            isr_q <= (isr_q & ~(wr_isr ? wdata_q[IRQ_BITS-1:0] : '0))
                | {start, pending_q & reload_point, cap_event};
        end
    end

    // ----------------------------------------------------------------
    // Outputs and read path
    // ----------------------------------------------------------------
    wire cmp = active_q & (tb_q < duty_act_q);
    pgs_status_t status;
    assign status = '{snapshot_flag: snap_flag_q, pending: pending_q,
                      pushpull_phase: phase_q,
                      centre_second_half: ctrl_q.centre & down_q,
                      cycle_active: active_q};

    wire [31:0] status_word = {26'h0, status[4:3], 1'b0, status[2:0]};
    wire [31:0] rd_mux =
        (s_axi_araddr == OFS_STATUS) ? status_word :
        (s_axi_araddr == OFS_CTRL) ? {28'h0, ctrl_q} :
        (s_axi_araddr == OFS_PERIOD) ? 32'(period_buf_q) :
        (s_axi_araddr == OFS_DUTY) ? 32'(duty_buf_q) :
        (s_axi_araddr == OFS_SNAPSHOT) ? 32'(snapshot_q) :
        (s_axi_araddr == OFS_IRQ_STATUS) ? 32'(isr_q) :
        (s_axi_araddr == OFS_IRQ_MASK) ? 32'(mask_q) : 32'h0;
    wire rd_mapped = (s_axi_araddr <= OFS_IRQ_MASK) & (s_axi_araddr[1:0] == 2'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
            pwm_a_q <= 1'b0;
            pwm_b_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            arready_q <= ~rvalid_d;
            rvalid_q <= rvalid_d;
            if (ar_take) begin
                rdata_q <= rd_mux;
                rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            pwm_a_q <= cmp & ~(ctrl_q.pushpull & phase_q);
            pwm_b_q <= cmp & ctrl_q.pushpull & phase_q;
            irq_q <= |(isr_q & mask_q);
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign pwm_a = pwm_a_q;
    assign pwm_b = pwm_b_q;
    assign irq = irq_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    wire sw_cap = wr_status & wdata_q[BIT_SNAPSHOT] & ~snap_flag_q & ~cap_pin_rise;
    wire sw_clr = wr_status & ~wdata_q[BIT_SNAPSHOT] & ~cap_event;

    property p_snap_latch;
        cap_event |=> snap_flag_q && snapshot_q == $past(tb_q);
    endproperty
    a_snap_latch: assert property (p_snap_latch) else $error("snapshot not latched");

    property p_sw_capture;
        sw_cap |-> ##[1:2] snap_flag_q;
    endproperty
    a_sw_capture: assert property (p_sw_capture) else $error("sw capture lost");

    property p_snap_hold;
        snap_flag_q && $past(snap_flag_q) |-> $stable(snapshot_q);
    endproperty
    a_snap_hold: assert property (p_snap_hold) else $error("capture while flag set");

    property p_data_locked;
        pending_q && (wr_period || wr_duty) |=> $stable(period_buf_q) && $stable(duty_buf_q);
    endproperty
    a_data_locked: assert property (p_data_locked) else $error("data written while pending");

    property p_req_reads_zero;
        ar_take && s_axi_araddr == OFS_STATUS |=> !rdata_q[BIT_RELOAD_REQ]
            && rdata_q[BIT_PENDING] == $past(pending_q);
    endproperty
    a_req_reads_zero: assert property (p_req_reads_zero) else $error("bad status read");

    property p_phase;
        cycle_end && ctrl_q.enable |=> phase_q == ($past(ctrl_q.pushpull) & ~$past(phase_q));
    endproperty
    a_phase: assert property (p_phase) else $error("phase did not flip");

    property p_half;
        status.centre_second_half |-> ctrl_q.centre && active_q;
    endproperty
    a_half: assert property (p_half) else $error("half set outside centre cycle");

    property p_idle_zero;
        !active_q ##1 !active_q |-> tb_q == '0;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("time base runs while idle");

    property p_reload_clears;
        pending_q && reload_point && !wr_status |=> !pending_q && period_act_q == $past(period_buf_q);
    endproperty
    a_reload_clears: assert property (p_reload_clears) else $error("reload not done");

    property p_zero_clears;
        sw_clr |=> !snap_flag_q;
    endproperty
    a_zero_clears: assert property (p_zero_clears) else $error("flag not cleared");

endmodule

`default_nettype wire

// [core/pgs_pkg.sv]
/*
 * Package for the PWM generator status block: register offsets, field
 * positions, reset values and the packed types shared by the design.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package pgs_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_PERIOD = 8'h08;
    localparam logic [7:0] OFS_DUTY = 8'h0c;
    localparam logic [7:0] OFS_SNAPSHOT = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    // ----------------------------------------------------------------
    // Status register fields
    // ----------------------------------------------------------------
    localparam int BIT_ACTIVE = 0;
    localparam int BIT_HALF = 1;
    localparam int BIT_PHASE = 2;
    localparam int BIT_RELOAD_REQ = 3;
    localparam int BIT_PENDING = 4;
    localparam int BIT_SNAPSHOT = 5;

    // Interrupt status / mask fields
    localparam int IRQ_BITS = 3;
    localparam int IRQ_CAPTURE = 0;
    localparam int IRQ_RELOADED = 1;
    localparam int IRQ_CYCLE = 2;

    // ----------------------------------------------------------------
    // Reset values and bus answers
    // ----------------------------------------------------------------
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [15:0] PERIOD_RESET = 16'h0010;
    localparam logic [15:0] DUTY_RESET = 16'h0008;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control register, bit 0 upward: enable, centre, pushpull, ext_cycle_active
    typedef struct packed {
        logic ext_cycle_active;
        logic pushpull;
        logic centre;
        logic enable;
    } pgs_ctrl_t;

    typedef struct packed {
        logic snapshot_flag;
        logic pending;
        logic pushpull_phase;
        logic centre_second_half;
        logic cycle_active;
    } pgs_status_t;

endpackage

// [verification/pwm_generator_status_flags_bench.sv]
/*
 * Self-checking bench for the PWM generator status block, driven over AXI4-Lite.
 * Assumes pgs_pkg and pgs_generator are compiled before this file.
 */
`timescale 1ns/1ps
`default_nettype none

module pwm_generator_status_flags_bench
    import pgs_pkg::*;
;
    typedef struct packed {
        logic rd;
        logic [1:0] resp;
        logic [31:0] data;
        logic [31:0] mask;
    } pgs_exp_t;

    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, cap_pin, trg_pin, pwm_a, pwm_b, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    pgs_exp_t exp_q[$];
    pgs_exp_t e_now;
    int failures, comparisons, cycles;

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    pgs_generator #(.TB_W(16)) i_pgs_generator (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .capture_pin(cap_pin),
        .trigger_pin(trg_pin), .pwm_a(pwm_a), .pwm_b(pwm_b), .irq(irq)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic finish_test();
        if (failures == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_on, w_on;
        aw_on = 1'b1;
        w_on = 1'b1;
        exp_q.push_back('{1'b0, r, 32'h0, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // Local flags: the valids read back stale in the step they are set
        while (aw_on || w_on) begin
            @(posedge aclk);
            if (aw_on && awready) begin
                awvalid <= 1'b0;
                aw_on = 1'b0;
            end
            if (w_on && wready) begin
                wvalid <= 1'b0;
                w_on = 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (!(bvalid && bready));
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic [1:0] r);
        exp_q.push_back('{1'b1, r, d, m});
        araddr <= a;
        arvalid <= 1'b1;
        // Ready raised once the address is taken, never twice in one step
        do begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                rready <= 1'b1;
            end
        end while (!(rvalid && rready));
        rready <= 1'b0;
    endtask

    // Pins held three cycles, wider than the synchroniser needs
    task automatic pulse(input logic [1:0] which);
        {trg_pin, cap_pin} <= which;
        repeat (3) @(posedge aclk);
        {trg_pin, cap_pin} <= 2'b00;
        repeat (6) @(posedge aclk);
    endtask

    // Output level used only as a timing reference inside the cycle
    task automatic wait_pwm(input logic b_side, input logic level);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while ((b_side ? pwm_b : pwm_a) !== level && n < 300);
        if (n >= 300) begin
            failures++;
            $display("wrong value at %0t: pwm edge never came", $time);
        end
    endtask

    // ----------------------------------------------------------------
    // Response monitor and timeout
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        cycles++;
        if ((rvalid && rready) || (bvalid && bready)) begin
            if (exp_q.size() == 0) begin
                failures++;
                $display("wrong value at %0t: unexpected response", $time);
            end else begin
                e_now = exp_q.pop_front();
                chk({31'h0, rvalid && rready}, {31'h0, e_now.rd}, "response kind");
                if (e_now.rd) begin
                    chk({30'h0, rresp}, {30'h0, e_now.resp}, "read resp");
                    chk(rdata & e_now.mask, e_now.data & e_now.mask, "read data");
                end else begin
                    chk({30'h0, bresp}, {30'h0, e_now.resp}, "write resp");
                end
            end
        end
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        failures = 0;
        comparisons = 0;
        cycles = 0;
        seed = 32'h1973;
        aresetn <= 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, cap_pin, trg_pin} <= 7'h00;
        awaddr <= 8'h00;
        araddr <= 8'h00;
        wdata <= 32'h0;
        wstrb <= 4'hf;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(OFS_STATUS, 32'h0, 32'h3f, RESP_OKAY);
        rd(OFS_CTRL, {28'h0, CTRL_RESET}, 32'hf, RESP_OKAY);
        rd(OFS_PERIOD, {16'h0, PERIOD_RESET}, 32'hffff, RESP_OKAY);
        rd(OFS_DUTY, {16'h0, DUTY_RESET}, 32'hffff, RESP_OKAY);
        rd(OFS_IRQ_MASK, 32'h0, 32'h7, RESP_OKAY);
        seed = xs(seed);
        wr(8'h40, seed, RESP_SLVERR);
        rd(8'h40, 32'h0, 32'hffffffff, RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(i[0] ? OFS_DUTY : OFS_PERIOD, seed, RESP_OKAY);
            rd(i[0] ? OFS_DUTY : OFS_PERIOD, seed, 32'hffff, RESP_OKAY);
        end
        wr(OFS_PERIOD, 32'h40, RESP_OKAY);
        wr(OFS_DUTY, 32'h8, RESP_OKAY);
        // Software capture, interrupt raise, clear and mask
        wr(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
        wr(OFS_STATUS, 32'h20, RESP_OKAY);
        repeat (4) @(posedge aclk);
        rd(OFS_STATUS, 32'h20, 32'h38, RESP_OKAY);
        chk({31'h0, irq}, 32'h1, "irq raised");
        wr(OFS_IRQ_STATUS, 32'h1, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        pulse(2'b01);
        rd(OFS_IRQ_STATUS, 32'h0, 32'h1, RESP_OKAY);
        wr(OFS_STATUS, 32'h0, RESP_OKAY);
        rd(OFS_STATUS, 32'h0, 32'h38, RESP_OKAY);
        pulse(2'b01);
        rd(OFS_STATUS, 32'h20, 32'h38, RESP_OKAY);
        rd(OFS_IRQ_STATUS, 32'h1, 32'h1, RESP_OKAY);
        chk({31'h0, irq}, 32'h1, "irq on pin capture");
        wr(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0, "irq masked");
        // Reload request issued at cycle start, refused buffer write
        wr(OFS_IRQ_STATUS, 32'h7, RESP_OKAY);
        wr(OFS_CTRL, 32'h1, RESP_OKAY);
        wait_pwm(1'b0, 1'b0);
        wait_pwm(1'b0, 1'b1);
        wr(OFS_STATUS, 32'h28, RESP_OKAY);
        rd(OFS_STATUS, 32'h31, 32'h39, RESP_OKAY);
        wr(OFS_DUTY, 32'h20, RESP_SLVERR);
        rd(OFS_DUTY, 32'h8, 32'hffff, RESP_OKAY);
        repeat (80) @(posedge aclk);
        rd(OFS_STATUS, 32'h21, 32'h39, RESP_OKAY);
        rd(OFS_IRQ_STATUS, 32'h2, 32'h2, RESP_OKAY);
        wr(OFS_DUTY, 32'h8, RESP_OKAY);
        // Centre mode halves
        wr(OFS_CTRL, 32'h3, RESP_OKAY);
        wait_pwm(1'b0, 1'b1);
        wait_pwm(1'b0, 1'b0);
        rd(OFS_STATUS, 32'h0, 32'h2, RESP_OKAY);
        wait_pwm(1'b0, 1'b1);
        rd(OFS_STATUS, 32'h2, 32'h2, RESP_OKAY);
        // Push-pull phases
        wr(OFS_CTRL, 32'h5, RESP_OKAY);
        wait_pwm(1'b0, 1'b0);
        wait_pwm(1'b0, 1'b1);
        rd(OFS_STATUS, 32'h0, 32'h4, RESP_OKAY);
        wait_pwm(1'b1, 1'b1);
        rd(OFS_STATUS, 32'h4, 32'h4, RESP_OKAY);
        // Externally triggered single cycle
        wr(OFS_CTRL, 32'h9, RESP_OKAY);
        repeat (150) @(posedge aclk);
        rd(OFS_STATUS, 32'h0, 32'h1, RESP_OKAY);
        wr(OFS_IRQ_STATUS, 32'h7, RESP_OKAY);
        pulse(2'b10);
        rd(OFS_STATUS, 32'h1, 32'h1, RESP_OKAY);
        chk({31'h0, pwm_b}, 32'h0, "pwm_b outside push-pull");
        rd(OFS_IRQ_STATUS, 32'h4, 32'h4, RESP_OKAY);
        repeat (100) @(posedge aclk);
        rd(OFS_STATUS, 32'h0, 32'h1, RESP_OKAY);
        repeat (4) @(posedge aclk);
        chk(exp_q.size(), 32'h0, "responses outstanding");
        finish_test();
    end
endmodule

`default_nettype wire
